// file: spi_wire_pkg.sv
/*
 * constants, pin bundles, configuration and state types for the serial port
 * assumes: one 10 MHz clock, 8-bit characters, pins sampled synchronously
 */
package spi_wire_pkg;

    // ****************************************************************
    // timing and format constants
    // ****************************************************************
    localparam int          CLK_PERIOD_NS = 100;     // clk period in ns
    localparam int          CHAR_BITS     = 8;       // bits in one character
    localparam logic [3:0]  SCALE_MAX     = 4'h8;    // largest legal scale
    localparam logic [1:0]  LANES_DUAL    = 2'h1;    // lane-count code for two lanes
    localparam logic [4:0]  EDGES_SINGLE  = 5'h10;   // sck edges per char, one lane
    localparam logic [4:0]  EDGES_DUAL    = 5'h08;   // sck edges per char, two lanes

    // ****************************************************************
    // bundles
    // ****************************************************************
    // configuration, change only while port_en is low
    typedef struct packed {
        logic       port_en;        // port enable
        logic       master;         // 1 master, 0 slave
        logic       three_wire;     // shared data line mode
        logic [1:0] lane_count;     // 1 selects dual-lane half duplex
        logic       cpol;           // clock idle level
        logic       cpha;           // sample on second edge when set
        logic       tx_fifo_en;     // transmit queue enable
        logic       rx_fifo_en;     // receive queue enable
        logic [3:0] scale;          // base clock divisor exponent
        logic [7:0] sck_high_count; // base clocks sck stays high
        logic [7:0] sck_low_count;  // base clocks sck stays low
    } cfg_t;

    // levels seen at the pins
    typedef struct packed {
        logic sck;                  // serial_clock_pin
        logic lane0;                // bidir_lane_zero / shared_data_line
        logic lane1;                // bidir_lane_one / slave_out_pin
        logic sel0_n;               // select_input_zero, active low
    } pins_in_t;

    // pin drive, an *_oe_n low means the pin is driven
    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic lane0;
        logic lane0_oe_n;
        logic lane1;
        logic lane1_oe_n;
        logic sel_n;
        logic sel_oe_n;
    } pins_out_t;

    // master sequencer states
    typedef enum logic [3:0] {
        M_IDLE   = 4'b0001,
        M_SELECT = 4'b0010,
        M_RUN    = 4'b0100,
        M_FINISH = 4'b1000
    } mst_state_t;

    // ****************************************************************
    // shared decodes
    // ****************************************************************
    // two-lane operation
    function automatic logic is_dual(input cfg_t c);
        return c.lane_count == LANES_DUAL;
    endfunction

    // direction is fixed per transfer
    function automatic logic is_half(input cfg_t c);
        return c.three_wire | is_dual(c);
    endfunction

    // sck edges that make up one character
    function automatic logic [4:0] char_edges(input cfg_t c);
        return is_dual(c) ? EDGES_DUAL : EDGES_SINGLE;
    endfunction

endpackage

// file: base_clk_div.sv
/*
 * internal base clock divider: one-cycle tick every 2**scale clocks
 * assumes: scale above the legal range is clamped to the top value
 */
`timescale 1ns/1ps
`default_nettype none

module base_clk_div
    import spi_wire_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // control
    input  wire logic       enable,
    input  wire logic [3:0] scale,
    // base clock enable
    output logic            tick
);

    logic [7:0] cnt_reg;    // cycles since last tick
    logic [3:0] scale_eff;  // clamped scale
    logic [8:0] limit;      // divisor minus one

    // ****************************************************************
    // divisor
    // ****************************************************************
    // divide by power
    always_comb begin
        scale_eff = (scale > SCALE_MAX) ? SCALE_MAX : scale;
        limit     = (9'h001 << scale_eff) - 9'h001;
        tick      = enable & ({1'b0, cnt_reg} == limit);
    end

    // counter, held at zero while disabled
    always_ff @(posedge clk) begin
        if (sys_rst || !enable || tick) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    a_div_one : assert property (@(posedge clk) disable iff (sys_rst)
        tick && scale == 4'h0 && enable |=> tick || !enable)
        else $error("scale 0 must tick every cycle");

    a_div_two : assert property (@(posedge clk) disable iff (sys_rst)
        tick && scale == 4'h1 && $stable(scale) |=> !tick ##1 (tick || !enable))
        else $error("scale 1 must tick every second cycle");

endmodule // base_clk_div

`default_nettype wire

// file: spi_wire_port.sv
/*
 * serial port wire format and clocking: master and slave shifter, three-wire,
 * dual-lane and four-wire pin control, sck generation
 * assumes: pins are synchronous to clk, pad logic resolves *_oe_n into the wire
 */
`timescale 1ns/1ps
`default_nettype none

module spi_wire_port (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // configuration
    input  wire spi_wire_pkg::cfg_t      cfg,
    // software queue side
    input  wire logic                    tx_write,
    input  wire logic [7:0]              tx_data,
    input  wire logic                    rx_read,
    output logic [7:0]                   rx_data,
    output logic                         rx_valid,
    output logic                         busy,
    // pins
    input  wire spi_wire_pkg::pins_in_t  pins_in,
    output var spi_wire_pkg::pins_out_t  pins_out
);
    import spi_wire_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    mst_state_t state_reg;      // master sequencer
    logic       base_tick;      // base clock enable
    logic [7:0] half_cnt_reg;   // base clocks left in current sck level
    logic       phase_reg;      // sck away from idle when set
    logic [4:0] edge_cnt_reg;   // sck edges done in this character
    logic [7:0] tx_reg;         // outgoing shifter
    logic [7:0] tx_hold_reg;    // last character written by software
    logic [7:0] rx_reg;         // incoming shifter
    logic       wr_dir_reg;     // current transfer drives data
    logic       sck_prev_reg;   // sck pin one cycle ago
    logic       rx_valid_reg;   // character received pulse
    logic [7:0] rx_data_reg;    // received character
    logic       selected;       // slave addressed
    logic       dir_tx;         // queue enables say write
    logic       dir_rx;         // queue enables say read
    logic       launch;         // master starts a transfer
    logic       launch_wr;      // that transfer writes
    logic       edge_now;       // an sck edge happens this cycle
    logic       sample_now;     // capture data this cycle
    logic       shift_now;      // present next bit this cycle
    logic       last_edge;      // edge that ends the character
    logic [1:0] in_bits;        // data seen on the lanes
    logic       sck_pin;        // master sck level

    // ****************************************************************
    // mode decode
    // ****************************************************************
    // queue direction
    always_comb begin
        dir_tx = cfg.tx_fifo_en & ~cfg.rx_fifo_en;
        dir_rx = cfg.rx_fifo_en & ~cfg.tx_fifo_en;
    end

    assign selected = cfg.port_en & ~cfg.master & ~pins_in.sel0_n;

    always_comb begin
        launch    = 1'b0;
        launch_wr = 1'b1;
        if (cfg.port_en && cfg.master && state_reg == M_IDLE) begin
            if (!is_half(cfg)) begin
                // full duplex, any write starts
                launch = tx_write;
            end else if (tx_write && dir_tx) begin
                launch = 1'b1;
            end else if (rx_read && dir_rx) begin
                launch    = 1'b1;
                launch_wr = 1'b0;
            end
        end
    end

    // ****************************************************************
    // base clock
    // ****************************************************************
    base_clk_div u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (cfg.port_en & cfg.master),
        .scale   (cfg.scale),
        .tick    (base_tick)
    );

    // ****************************************************************
    // edge decode
    // ****************************************************************
    // sck source by role
    always_comb begin
        if (cfg.master) begin
            edge_now = (state_reg == M_RUN) & base_tick & (half_cnt_reg <= 8'h01);
        end else begin
            edge_now = selected & (pins_in.sck != sck_prev_reg);
        end
        sample_now = edge_now & (~edge_cnt_reg[0] ^ cfg.cpha);
        shift_now  = edge_now & ~(~edge_cnt_reg[0] ^ cfg.cpha) & (edge_cnt_reg != 5'h00);
        last_edge  = edge_now & (edge_cnt_reg == char_edges(cfg) - 5'h01);
    end

    always_comb begin
        if (is_dual(cfg)) begin
            in_bits = {pins_in.lane1, pins_in.lane0};
        end else if (cfg.master && !cfg.three_wire) begin
            in_bits = {1'b0, pins_in.lane1};
        end else begin
            in_bits = {1'b0, pins_in.lane0};
        end
    end

    // ****************************************************************
    // master sequencer
    // ****************************************************************
    // select then clock
    always_ff @(posedge clk) begin
        if (sys_rst || !cfg.port_en || !cfg.master) begin
            state_reg <= M_IDLE;
        end else begin
            unique case (state_reg)
                M_IDLE: begin
                    if (launch) begin
                        state_reg <= M_SELECT;
                    end
                end
                M_SELECT: begin
                    if (base_tick) begin
                        state_reg <= M_RUN;
                    end
                end
                M_RUN: begin
                    if (last_edge) begin
                        state_reg <= M_FINISH;
                    end
                end
                M_FINISH: begin
                    if (base_tick) begin
                        state_reg <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // transfer direction latched at launch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_dir_reg <= 1'b1;
        end else if (launch) begin
            wr_dir_reg <= launch_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || state_reg == M_IDLE) begin
            phase_reg    <= 1'b0;
            half_cnt_reg <= 8'h00;
        end else if (state_reg == M_SELECT && base_tick) begin
            half_cnt_reg <= cfg.cpol ? cfg.sck_high_count : cfg.sck_low_count;
        end else if (edge_now) begin
            phase_reg    <= ~phase_reg;
            half_cnt_reg <= (~phase_reg ^ cfg.cpol) ? cfg.sck_high_count : cfg.sck_low_count;
        end else if (state_reg == M_RUN && base_tick) begin
            half_cnt_reg <= half_cnt_reg - 8'h01;
        end
    end

    assign sck_pin = phase_reg ^ cfg.cpol;

    // ****************************************************************
    // shifters
    // ****************************************************************
    // edge counter, slave wraps per character
    always_ff @(posedge clk) begin
        if (sys_rst || launch || (!cfg.master && !selected)) begin
            edge_cnt_reg <= 5'h00;
        end else if (edge_now) begin
            edge_cnt_reg <= (!cfg.master && last_edge) ? 5'h00 : edge_cnt_reg + 5'h01;
        end
    end

    // software transmit holding
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_hold_reg <= 8'h00;
        end else if (tx_write) begin
            tx_hold_reg <= tx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_reg <= 8'h00;
        end else if (launch) begin
            tx_reg <= tx_data;
        end else if (!cfg.master && (!selected || last_edge)) begin
            tx_reg <= tx_hold_reg;
        end else if (shift_now) begin
            tx_reg <= is_dual(cfg) ? {tx_reg[5:0], 2'b00} : {tx_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_reg <= 8'h00;
        end else if (sample_now) begin
            rx_reg <= is_dual(cfg) ? {rx_reg[5:0], in_bits} : {rx_reg[6:0], in_bits[0]};
        end
    end

    // received character and pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_valid_reg <= 1'b0;
            rx_data_reg  <= 8'h00;
        end else begin
            rx_valid_reg <= 1'b0;
            if (last_edge && (!is_half(cfg) || (cfg.master ? !wr_dir_reg : !dir_tx))) begin
                rx_valid_reg <= 1'b1;
                if (sample_now) begin
                    // last edge samples, take the final bits from the lanes
                    rx_data_reg <= is_dual(cfg) ? {rx_reg[5:0], in_bits} : {rx_reg[6:0], in_bits[0]};
                end else begin
                    // last edge only shifts, the character is already complete
                    rx_data_reg <= rx_reg;
                end
            end
        end
    end

    // slave clock history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= pins_in.sck;
        end
    end

    // ****************************************************************
    // pin drive
    // ****************************************************************
    always_comb begin
        pins_out            = '1;
        pins_out.lane0      = is_dual(cfg) ? tx_reg[6] : tx_reg[7];
        pins_out.lane1      = tx_reg[7];
        pins_out.sck        = sck_pin;
        if (cfg.port_en && cfg.master) begin
            pins_out.sck_oe_n = 1'b0;
            pins_out.sel_oe_n = 1'b0;
            pins_out.sel_n    = (state_reg == M_IDLE);
            if (!is_half(cfg)) begin
                pins_out.lane0_oe_n = 1'b0;
            end else if (state_reg != M_IDLE && wr_dir_reg) begin
                pins_out.lane0_oe_n = 1'b0;
                pins_out.lane1_oe_n = ~is_dual(cfg);
            end
        end else if (selected) begin
            if (!is_half(cfg)) begin
                pins_out.lane1_oe_n = 1'b0;
                pins_out.lane1      = tx_reg[7];
            end else if (dir_tx) begin
                pins_out.lane0_oe_n = 1'b0;
                pins_out.lane1_oe_n = ~is_dual(cfg);
            end
        end
    end

    assign rx_data  = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign busy     = cfg.master ? (state_reg != M_IDLE) : selected;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_idle_to_select;
        state_reg == M_IDLE ##1 state_reg == M_SELECT;
    endsequence

    sequence s_clock_moves;
        cfg.master && $changed(phase_reg);
    endsequence

    a_disabled_hiz : assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.port_en |-> pins_out.sck_oe_n && pins_out.lane0_oe_n && pins_out.lane1_oe_n && pins_out.sel_oe_n)
        else $error("pins driven while disabled");

    a_sel_before_clk : assert property (@(posedge clk) disable iff (sys_rst)
        s_clock_moves |-> !pins_out.sel_n && $past(!pins_out.sel_n))
        else $error("sck moved before select asserted");

    a_select_first : assert property (@(posedge clk) disable iff (sys_rst)
        s_idle_to_select |-> !pins_out.sel_n && !phase_reg)
        else $error("select not first on launch");

    a_read_release : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.master && is_half(cfg) && state_reg == M_RUN && !wr_dir_reg |-> pins_out.lane0_oe_n)
        else $error("master drives data during read");

    a_write_drive : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.port_en && cfg.master && cfg.three_wire && state_reg == M_RUN && wr_dir_reg |-> !pins_out.lane0_oe_n)
        else $error("master not driving during write");

    a_launch_read : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.port_en && cfg.master && cfg.three_wire && state_reg == M_IDLE && rx_read && dir_rx && !tx_write
        |=> state_reg == M_SELECT && !wr_dir_reg)
        else $error("queue read did not launch read");

    a_slave_ignore : assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.master && pins_in.sel0_n |=> edge_cnt_reg == 5'h00 && !rx_valid)
        else $error("unselected slave reacted");

    a_slave_release : assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.master && pins_in.sel0_n |-> pins_out.lane0_oe_n && pins_out.lane1_oe_n)
        else $error("deselected slave drives data");

    a_lane_count : assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == M_RUN ##1 state_reg == M_FINISH |-> edge_cnt_reg == (is_dual(cfg) ? 5'h08 : 5'h10))
        else $error("wrong edge count per character");

    a_high_time : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.master && state_reg == M_RUN && $rose(sck_pin) && cfg.scale == 4'h0 && cfg.sck_high_count == 8'h02
        && edge_cnt_reg < 5'h07 |-> sck_pin[*2] ##1 !sck_pin)
        else $error("sck high time wrong");

    a_idle_level : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.port_en && cfg.master && state_reg == M_IDLE |-> pins_out.sck == cfg.cpol)
        else $error("sck idle level wrong");

    a_mode_edges : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.master && sample_now && $stable(cfg) |=> pins_out.sck == (cfg.cpha ? cfg.cpol : !cfg.cpol))
        else $error("sample on wrong sck edge");

    a_data_lead : assert property (@(posedge clk) disable iff (sys_rst)
        cfg.master && state_reg == M_RUN && $changed(tx_reg) |-> $past(shift_now))
        else $error("data changed off the shift edge");

endmodule // spi_wire_port

`default_nettype wire

// file: spi_far_slave.sv
/* far-end slave model for master-mode tests
   assumes: sck and sel_n change just after clk edges */
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
    // clock and pins
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    // mode and data
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic       sck_q; // last seen sck
    logic       first; // no leading edge yet
    logic [7:0] sh;    // outgoing shifter
    // released line shows inverse of the top shifter bit
    assign miso = sel_n ? ~sh[7] : sh[7];
    // sample on one edge, shift on the other
    always @(posedge clk) begin
        sck_q <= sck;
        if (sel_n) begin
            sh    <= tx_byte;
            first <= 1'b1;
        end else if (sck != sck_q) begin
            if (((sck != cpol) ^ cpha) != 1'b0)
                rx_byte <= {rx_byte[6:0], mosi};
            else if (!first || !cpha)
                sh <= {sh[6:0], 1'b0};
            if (sck != cpol)
                first <= 1'b0;
        end
    end
endmodule // spi_far_slave
`default_nettype wire

// file: spi_wire_port_tb.sv
/* self-checking bench for the serial port wire format
   assumes: spi_far_slave answers in master mode, bench drives pins in slave mode */
`timescale 1ns/1ps
`default_nettype none
module spi_wire_port_tb;
    import spi_wire_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, tx_write = 1'b0, rx_read = 1'b0;
    logic [7:0] tx_data = 8'h00, ptx = 8'h00, rx_data, prx;
    cfg_t cfg = '0;
    pins_in_t pin_m, pins_in, pin_s = 4'h7;
    pins_out_t pins_out;
    logic rx_valid, busy, miso, sck_q, drv0, drv1;
    logic [7:0] sh_s = 8'h00; // slave_out_pin bits seen by the bench master
    int err_total = 0, n_tests = 0, cyc = 0, edges = 0, nrx = 0, e0, v0, r2_bad = 0;
    int hi_n = 0, lo_n = 0, hi_last = 0, lo_last = 0;
    always #50 clk = ~clk;
    spi_wire_port i_dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .tx_write(tx_write), .tx_data(tx_data),
        .rx_read(rx_read), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .pins_in(pins_in),
        .pins_out(pins_out));
    spi_far_slave i_far (.clk(clk), .sck(pins_out.sck), .sel_n(pins_out.sel_n), .mosi(pin_m.lane0),
        .cpol(cfg.cpol), .cpha(cfg.cpha), .tx_byte(ptx), .miso(miso), .rx_byte(prx));
    // shared lines resolved from both drivers
    assign pin_m = '{pins_out.sck, pins_out.lane0_oe_n ? miso : pins_out.lane0,
                     pins_out.lane1_oe_n ? miso : pins_out.lane1, 1'b1};
    assign pins_in = cfg.master ? pin_m : pin_s;
    // wire watch: edges, sck run lengths, drivers, timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sck_q <= pins_out.sck;
        nrx <= nrx + int'(rx_valid);
        if (pins_out.sck != sck_q && !pins_out.sel_n) edges <= edges + 1;
        if (pins_out.sck != sck_q && pins_out.sel_n && busy) r2_bad <= r2_bad + 1;
        if (!pins_out.sel_n && !pins_out.lane0_oe_n) drv0 <= 1'b1;
        if (!pins_out.sel_n && !pins_out.lane1_oe_n) drv1 <= 1'b1;
        hi_n <= (pins_out.sck && !pins_out.sel_n) ? hi_n + 1 : 0;
        lo_n <= (!pins_out.sck && !pins_out.sel_n) ? lo_n + 1 : 0;
        if (!pins_out.sck && sck_q) hi_last <= hi_n;
        if (pins_out.sck && !sck_q) lo_last <= lo_n;
        if (cyc > 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(string nm, logic e, logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    // reconfigure only with the port off
    task automatic setc(logic m, tw, logic [1:0] ln, logic pol, pha, te, re, logic [3:0] sc, logic [7:0] h, l);
        @(posedge clk) cfg.port_en <= 1'b0;
        @(posedge clk) cfg <= '{1'b0, m, tw, ln, pol, pha, te, re, sc, h, l};
        @(posedge clk) cfg.port_en <= 1'b1;
        @(posedge clk) #1;
    endtask
    // one queue request, then wait for the port to go idle
    task automatic go(logic rd, logic [7:0] d);
        int i;
        e0 = edges;
        v0 = nrx;
        drv0 = 1'b0;
        drv1 = 1'b0;
        @(posedge clk) begin
            tx_write <= !rd;
            rx_read  <= rd;
            tx_data  <= d;
        end
        @(posedge clk) begin
            tx_write <= 1'b0;
            rx_read  <= 1'b0;
        end
        #1;
        for (i = 0; i < 3000 && busy === 1'b1; i++) @(posedge clk) #1;
        chk1("busy end", 1'b0, busy);
        repeat (3) @(posedge clk) #1;
    endtask
    // bench acts as mode 0 master on the slave's pins
    task automatic bang(logic sn, logic [7:0] d);
        for (int i = 15; i >= -1; i--) begin
            @(posedge clk) pin_s <= '{~i[0], d[i/2], 1'b1, sn};
            repeat (2) @(posedge clk);
            #1;
            // capture the slave's bit late in each high phase
            if (!i[0]) sh_s = {sh_s[6:0], pins_out.lane1};
        end
        @(posedge clk) pin_s <= 4'h7;
        repeat (4) @(posedge clk) #1;
    endtask
    task automatic print_verdict();
        $display("counts tests %0d bad %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk) #1;
        chk8("oe off", 8'h0f, {4'h0, pins_out.sck_oe_n, pins_out.lane0_oe_n, pins_out.lane1_oe_n,
             pins_out.sel_oe_n});
        for (int m = 0; m < 4; m++) begin
            ptx = 8'h5a ^ 8'(m * 17);
            setc(1'b1, 1'b0, 2'h0, m[0], m[1], 1'b1, 1'b1, 4'h0, 8'h02, 8'h02);
            chk1("sck idle", m[0], pins_out.sck);
            go(1'b0, 8'h3c + 8'(m));
            chk8("far rx", 8'h3c + 8'(m), prx);
            chk8("dut rx", ptx, rx_data);
            chk8("edges", 8'h10, 8'(edges - e0));
            chk8("rx count", 8'h01, 8'(nrx - v0));
        end
        $display("test modes done");
        setc(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h1, 8'h03, 8'h02);
        go(1'b0, 8'ha5);
        chk8("sck high", 8'h06, 8'(hi_last));
        chk8("sck low", 8'h04, 8'(lo_last));
        chk8("early sck", 8'h00, 8'(r2_bad));
        $display("test rate done");
        setc(1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h02, 8'h02);
        go(1'b0, 8'hc3);
        chk8("far rx", 8'hc3, prx);
        chk1("lane0 drv", 1'b1, drv0);
        ptx = 8'h96;
        setc(1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 8'h02, 8'h02);
        go(1'b1, 8'h00);
        chk8("dut rx", 8'h96, rx_data);
        chk1("lane0 drv", 1'b0, drv0);
        setc(1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 8'h02, 8'h02);
        go(1'b0, 8'h11);
        chk8("edges", 8'h00, 8'(edges - e0));
        $display("test three wire done");
        setc(1'b1, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h02, 8'h02);
        go(1'b0, 8'h77);
        chk8("edges", 8'h08, 8'(edges - e0));
        chk1("lane1 drv", 1'b1, drv1);
        $display("test dual done");
        setc(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 8'h02, 8'h02);
        v0 = nrx;
        bang(1'b1, 8'hff);
        chk8("rx count", 8'h00, 8'(nrx - v0));
        chk1("lane1 oe", 1'b1, pins_out.lane1_oe_n);
        bang(1'b0, 8'hb4);
        chk8("dut rx", 8'hb4, rx_data);
        // holding register still carries the dual test's character
        chk8("slave tx", 8'h77, sh_s);
        chk8("rx count", 8'h01, 8'(nrx - v0));
        $display("test slave done");
        print_verdict();
    end
endmodule // spi_wire_port_tb
`default_nettype wire
